// *** lrad_cfg.svh ***
// Address map, register layout and reset constants for the local RAM and address decode block.
`ifndef LRAD_CFG_SVH
`define LRAD_CFG_SVH
`define LRAD_FETCH_RAM_BASE   32'h00000000
`define LRAD_DATA_RAM_BASE    32'h00010000
`define LRAD_BANK_SEL_BIT     14
`define LRAD_WIN_LSB          15
`define LRAD_ROM_SEL          2'h2
`define LRAD_RES_SEL          2'h3
`define LRAD_CFG_BASE         32'h01C00000
`define LRAD_CFG_LAST         32'h01FFFFFF
`define LRAD_CE0_BASE         32'h02000000
`define LRAD_CE0_LAST         32'h03FFFFFF
`define LRAD_CE1_BASE         32'h04000000
`define LRAD_CE1_LAST         32'h05FFFFFF
`define LRAD_TRC_BASE         32'h01BC0000
`define LRAD_TRC_LAST         32'h01BC0FFF
`define LRAD_DDR_BASE         32'h80000000
`define LRAD_DDR_LAST         32'h8FFFFFFF
`define LRAD_CRN_STATUS       4'h0
`define LRAD_CRN_REGION       4'h9
`define LRAD_OP2_STATUS       3'h2
`define LRAD_OP2_DATA         3'h0
`define LRAD_OP2_FETCH        3'h1
`define LRAD_DATA_PRESENT_BIT 16
`define LRAD_FETCH_PRESENT_BIT 0
`define LRAD_ENABLE_BIT       0
`define LRAD_SIZE_HI          5
`define LRAD_SIZE_LO          2
`define LRAD_BASE_LO          12
`define LRAD_SIZE_MIN         4'h3
`define LRAD_SIZE_MAX         4'hB
`define LRAD_DATA_REG_RESET   32'h00010019
`define LRAD_FETCH_REG_RESET  32'h00000019
`define LRAD_REG_WMASK        32'hFFFFF03D
`endif

// *** lrad_pkg.sv ***
// Types shared by the local RAM and address decode block.
package lrad_pkg;
  // Decoded target of one access.
  typedef enum logic [8:0] {
    LRAD_TGT_NONE  = 9'h001,
    LRAD_TGT_BANK0 = 9'h002,
    LRAD_TGT_BANK1 = 9'h004,
    LRAD_TGT_ROM   = 9'h008,
    LRAD_TGT_TRACE = 9'h010,
    LRAD_TGT_CFG   = 9'h020,
    LRAD_TGT_CE0   = 9'h040,
    LRAD_TGT_CE1   = 9'h080,
    LRAD_TGT_DDR   = 9'h100
  } lrad_target_t;
  // Which bus master presents an access on the system port.
  typedef enum logic [1:0] {
    LRAD_MST_CPU  = 2'h0,
    LRAD_MST_DMA  = 2'h1,
    LRAD_MST_PERI = 2'h2,
    LRAD_MST_VID  = 2'h3
  } lrad_master_t;
endpackage : lrad_pkg

// *** lrad_local_ram_decode.sv ***
// Local RAM banks, ROM, region registers and per-master address decode.
//
// Contract
// (RQ1) Fetch window maps RAM at 0..32KB.
// (RQ2) Data window maps RAM at 64KB..96KB.
// (RQ3) Two 16KB banks; different banks same cycle.
// (RQ4) 16KB ROM directly above both banks.
// (RQ5) Status bit 16 shows data RAM present.
// (RQ6) Status bit 0 shows fetch RAM present.
// (RQ7) Status read at c0,c0, opcode2 two.
// (RQ8) Region registers at c9,c0 opcode2 0/1.
// (RQ9) Region base held in bits 31..12.
// (RQ10) Size code bits 5..2; reserved codes absent; code 2 still opens 4KB of fetch RAM.
// (RQ11) Enable bit 0 resets to one.
// (RQ12) Software writes 0x00010019 to enable data RAM.
// (RQ13) Each master has its own address map.
// (RQ14) Config space routes to configuration peripherals.
// (RQ15) Two 32MB async chip-select windows.
// (RQ16) Trace goes to 4KB on-chip trace buffer.
// (RQ17) Trace macrocell compresses trace for narrow port.
// (RQ18) Coprocessor access only in privileged mode.
// (RQ19) Reserved accesses answer defined, corrupt nothing.
`timescale 1ns/1ps
`include "lrad_cfg.svh"
module lrad_local_ram_decode #(
  parameter int BANK_WORDS = 4096,              // Words per 16KB bank.
  parameter int ROM_WORDS  = 4096,              // Words in the 16KB ROM.
  parameter int AW         = 12                 // Word index width within a bank.
) (
  input  wire logic                    clock,          // Processor clock.
  input  wire logic                    rst,            // Synchronous reset, high.
  input  wire logic                    fetchReq,       // Fetch port request.
  input  wire logic [31:0]             fetchAddr,      // Fetch physical address.
  output logic      [31:0]             fetchData,      // Fetch read data.
  output logic                         fetchHit,       // Fetch answered locally.
  output logic                         fetchErr,       // Fetch hit reserved space.

  input  wire logic                    dataReq,        // Data port request.
  input  wire logic                    dataWrite,      // Data port write.
  input  wire logic [3:0]              dataBe,         // Data byte enables.
  input  wire logic [31:0]             dataAddr,       // Data physical address.
  input  wire logic [31:0]             dataWdata,      // Data write data.
  output logic      [31:0]             dataRdata,      // Data read data.
  output logic                         dataHit,        // Data answered locally.
  output logic                         dataErr,        // Data hit reserved space.

  input  wire logic                    sysReq,         // System port request.
  input  wire lrad_pkg::lrad_master_t  sysMaster,      // Master of system access.
  input  wire logic [31:0]             sysAddr,        // System address.
  output lrad_pkg::lrad_target_t       sysTarget,      // Routed target.
  output logic                         sysErr,         // Reserved for that master.

  input  wire logic                    cpReq,          // Coprocessor transfer valid.
  input  wire logic                    cpWrite,        // Write transfer when high.
  input  wire logic                    cpPriv,         // Core is privileged.
  input  wire logic [3:0]              cpCrn,          // Primary register number.
  input  wire logic [3:0]              cpCrm,          // Secondary register number.
  input  wire logic [2:0]              cpOp2,          // Opcode2 selector.
  input  wire logic [31:0]             cpWdata,        // Write data from core.
  output logic      [31:0]             cpRdata,        // Read data to core.
  output logic                         cpAck,          // Transfer accepted pulse.
  output logic                         cpUndef,        // Transfer refused pulse.

  output logic [31:0]                  dataRegion,     // Data region register view.
  output logic [31:0]                  fetchRegion     // Fetch region register view.
);

  // Answers come from flip-flops, one cycle late.

  // Address map of one local window, relative to its base:
  //   0KB to 16KB is the low RAM bank.
  //   16KB to 32KB is the high RAM bank.
  //   32KB to 48KB is the ROM.
  //   48KB to 64KB is reserved and answers with an error.
  // The fetch base is 0 and the data base is 64KB.
  // Other masters reach the data-side alias only.
  // Fetch and data may hit one bank together.
  // The region size sets how far RAM reaches.
  // A size below 32KB hides part of the banks on the data side; on the fetch side any size of 16KB or less does.
  // The ROM quarter stays open at any legal size.
  // Writes to ROM are dropped without an error.
  // Reserved quarters give an error pulse.
  // Reserved size codes open no RAM window, except code 2 on the fetch side, where the doubled match opens 4KB; the ROM quarter still answers.
  // A disabled region opens nothing on the fetch or data port; the system port still routes the fixed data-side alias.
  // Reads of RAM never change its contents.
  // Both ports index words, not bytes.
  // Byte enables only matter on writes.

  // Storage: two RAM banks held in flip-flops and a constant ROM image.

  logic [31:0] bankLow  [BANK_WORDS];  // Low 16KB bank.
  logic [31:0] bankHigh [BANK_WORDS];  // High 16KB bank.
  logic [31:0] romImage [ROM_WORDS];   // ROM contents, fixed at zero here.

  // Region registers, reset to enabled 32KB windows at the default bases.
  logic [31:0] dataReg;                // Data-side region register.
  logic [31:0] fetchReg;               // Fetch-side region register.

  // Window match for a local region: enabled, legal size, base match.
  // A reserved size code reads back but opens no window, so nothing is touched.
  // Code 3 is 4KB and each step doubles it.
  function automatic logic regionHit(input logic [31:0] rgn, input logic [31:0] addr);
    logic [3:0]  code;   // Size code field.
    logic        legal;  // Code names a real size.
    logic [31:0] mask;   // Clears the offset bits.

    code  = rgn[`LRAD_SIZE_HI:`LRAD_SIZE_LO];                        // [RQ10]
    legal = (code >= `LRAD_SIZE_MIN) && (code <= `LRAD_SIZE_MAX);    // [RQ10] [RQ19]
    mask  = ~((32'h00000200 << code) - 32'h00000001);               // [RQ10]

    return rgn[`LRAD_ENABLE_BIT] && legal &&
           ((addr & mask) == ({rgn[31:`LRAD_BASE_LO], 12'h000} & mask)); // [RQ9] [RQ11]
  endfunction : regionHit

  // Window offset selects bank low, bank high, ROM or reserved quarter.
  // Quarter 3 is never a hit.
  function automatic logic [1:0] quarter(input logic [31:0] addr);
    return addr[`LRAD_WIN_LSB:`LRAD_BANK_SEL_BIT];                    // [RQ3] [RQ4]
  endfunction : quarter

  // Fetch side: region match covers 0..32KB RAM plus the ROM above it.
  // A doubled window opens fetch RAM at twice the region size for even size codes 2 to 10; the ROM quarter matches by itself.
  wire logic        fetchWin  = regionHit(fetchReg, fetchAddr) ||
                                (fetchReg[`LRAD_ENABLE_BIT] &&
                                 regionHit(fetchReg | 32'h00000004, fetchAddr));

  wire logic [1:0]  fetchQ    = quarter(fetchAddr);

  wire logic        fetchLocal = fetchReq && (fetchAddr[31:16] == fetchReg[31:16]) &&
                                 fetchReg[`LRAD_ENABLE_BIT];          // [RQ1]

  wire logic        fetchOk   = fetchLocal && (fetchQ != `LRAD_RES_SEL) &&
                                (fetchWin || fetchQ == `LRAD_ROM_SEL); // [RQ4] [RQ19]

  // Word index within a bank.
  wire logic [AW-1:0] fetchIdx = fetchAddr[AW+1:2];

  // Data side: same layout relative to the data base.
  // A disabled region gives no hit and no error.
  wire logic        dataWin   = regionHit(dataReg, dataAddr);

  wire logic [1:0]  dataQ     = quarter(dataAddr);

  wire logic        dataLocal = dataReq && (dataAddr[31:16] == dataReg[31:16]) &&
                                dataReg[`LRAD_ENABLE_BIT];            // [RQ2]

  wire logic        dataOk    = dataLocal && (dataQ != `LRAD_RES_SEL) &&
                                (dataWin || dataQ == `LRAD_ROM_SEL);  // [RQ4] [RQ19]

  wire logic        dataRam   = dataOk && !dataQ[1];

  // Word index within a bank.
  wire logic [AW-1:0] dataIdx = dataAddr[AW+1:2];

  // Writes only reach RAM; ROM and reserved writes are dropped.
  // A dropped write still answers, so the core never stalls.
  wire logic wrLow  = dataRam && dataWrite && (dataQ == 2'h0);       // [RQ19]

  wire logic wrHigh = dataRam && dataWrite && (dataQ == 2'h1);       // [RQ19]

  // Byte-merge write data onto the old word.
  // Lanes with a clear enable keep old bytes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;

    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Bank writes; each bank has its own port so both sides run in one cycle.
  // Banks have no reset; contents start unknown.
  always_ff @(posedge clock) begin
    if (wrLow) begin
      bankLow[dataIdx] <= merge(bankLow[dataIdx], dataWdata, dataBe);  // [RQ3]
    end

    if (wrHigh) begin
      bankHigh[dataIdx] <= merge(bankHigh[dataIdx], dataWdata, dataBe); // [RQ3]
    end
  end

  // ROM image is tied to zero; a real mask image replaces this constant.
  // Synthesis folds this into constants.
  always_comb begin
    for (int i = 0; i < ROM_WORDS; i++) begin
      romImage[i] = 32'h00000000;
    end
  end

  // Read selection per side; a shared bank means the data side still completes,
  // since each bank is read combinationally by both ports at once.
  wire logic [31:0] fetchSel = (fetchQ == 2'h0) ? bankLow[fetchIdx] :
                               (fetchQ == 2'h1) ? bankHigh[fetchIdx] : romImage[fetchIdx];

  wire logic [31:0] dataSel  = (dataQ == 2'h0) ? bankLow[dataIdx] :
                               (dataQ == 2'h1) ? bankHigh[dataIdx] : romImage[dataIdx];

  // Registered answers for both local ports, one cycle after the request.
  // Each answer stands for one cycle only.
  always_ff @(posedge clock) begin
    if (rst) begin
      fetchData <= 32'h00000000;
      fetchHit  <= 1'b0;
      fetchErr  <= 1'b0;
      dataRdata <= 32'h00000000;
      dataHit   <= 1'b0;
      dataErr   <= 1'b0;
    end else begin
      fetchData <= fetchOk ? fetchSel : 32'h00000000;                 // [RQ1] [RQ3]
      fetchHit  <= fetchOk;
      fetchErr  <= fetchLocal && !fetchOk;                            // [RQ19]

      dataRdata <= (dataOk && !dataWrite) ? dataSel : 32'h00000000;    // [RQ2] [RQ3]
      dataHit   <= dataOk;
      dataErr   <= dataLocal && !dataOk;                              // [RQ19]
    end
  end

  // Coprocessor register decode.
  // The secondary number must be zero for all three.
  wire logic cpStat  = (cpCrn == `LRAD_CRN_STATUS) && (cpCrm == 4'h0) &&
                       (cpOp2 == `LRAD_OP2_STATUS);                   // [RQ7]

  wire logic cpDreg  = (cpCrn == `LRAD_CRN_REGION) && (cpCrm == 4'h0) &&
                       (cpOp2 == `LRAD_OP2_DATA);                     // [RQ8]

  wire logic cpFreg  = (cpCrn == `LRAD_CRN_REGION) && (cpCrm == 4'h0) &&
                       (cpOp2 == `LRAD_OP2_FETCH);                    // [RQ8]

  wire logic cpLegal = cpReq && cpPriv && (cpDreg || cpFreg || (cpStat && !cpWrite)); // [RQ18]

  // Presence word: only the two documented bits are ever set.
  // Both memories are always built in.
  wire logic [31:0] statusWord =
    (32'h00000001 << `LRAD_DATA_PRESENT_BIT) |
    (32'h00000001 << `LRAD_FETCH_PRESENT_BIT);                        // [RQ5] [RQ6]

  // Region registers; only address, size and enable bits are writable.
  // Reserved bits read back as zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      dataReg  <= `LRAD_DATA_REG_RESET;                               // [RQ11] [RQ12]
      fetchReg <= `LRAD_FETCH_REG_RESET;                              // [RQ11]
    end else if (cpLegal && cpWrite) begin
      if (cpDreg) begin
        dataReg <= cpWdata & `LRAD_REG_WMASK;                         // [RQ8] [RQ9]
      end

      if (cpFreg) begin
        fetchReg <= cpWdata & `LRAD_REG_WMASK;                        // [RQ8] [RQ9]
      end
    end
  end

  // Coprocessor answer; refused transfers get an undefined pulse instead.
  // A refused read returns zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      cpRdata <= 32'h00000000;
      cpAck   <= 1'b0;
      cpUndef <= 1'b0;
    end else begin
      cpAck   <= cpLegal;

      cpUndef <= cpReq && !cpLegal;                                   // [RQ18] [RQ19]

      cpRdata <= (!cpLegal || cpWrite) ? 32'h00000000 :
                 cpStat ? statusWord : cpDreg ? dataReg : fetchReg;   // [RQ7]
    end
  end

  // Live register views for the fabric.
  assign dataRegion  = dataReg;
  assign fetchRegion = fetchReg;

  // System decode: shared windows first, then the per-master view.
  wire logic inCfg   = (sysAddr >= `LRAD_CFG_BASE) && (sysAddr <= `LRAD_CFG_LAST); // [RQ14]
  wire logic inCe0   = (sysAddr >= `LRAD_CE0_BASE) && (sysAddr <= `LRAD_CE0_LAST); // [RQ15]
  wire logic inCe1   = (sysAddr >= `LRAD_CE1_BASE) && (sysAddr <= `LRAD_CE1_LAST); // [RQ15]
  wire logic inTrc   = (sysAddr >= `LRAD_TRC_BASE) && (sysAddr <= `LRAD_TRC_LAST); // [RQ16]
  wire logic inDdr   = (sysAddr >= `LRAD_DDR_BASE) && (sysAddr <= `LRAD_DDR_LAST);

  // Fixed data-side alias seen by other masters.
  wire logic [31:0] dataBaseWord = `LRAD_DATA_RAM_BASE;
  wire logic inLocal = (sysAddr[31:16] == dataBaseWord[31:16]);
  wire logic [1:0] sysQ = quarter(sysAddr);

  wire logic cpuOrDma = (sysMaster == lrad_pkg::LRAD_MST_CPU) ||
                        (sysMaster == lrad_pkg::LRAD_MST_DMA);
  wire logic notVideo = (sysMaster != lrad_pkg::LRAD_MST_VID);

  // Route per master; the video master sees only DDR here.
  // Trace arrives compressed by the macrocell; only its buffer is routed. [RQ17]
  lrad_pkg::lrad_target_t nextTarget;
  always_comb begin
    nextTarget = lrad_pkg::LRAD_TGT_NONE;

    if (inDdr) begin
      nextTarget = lrad_pkg::LRAD_TGT_DDR;

    end else if (inCfg && notVideo) begin
      nextTarget = lrad_pkg::LRAD_TGT_CFG;                            // [RQ14] [RQ13]

    end else if (inCe0 && cpuOrDma) begin
      nextTarget = lrad_pkg::LRAD_TGT_CE0;                            // [RQ15] [RQ13]

    end else if (inCe1 && cpuOrDma) begin
      nextTarget = lrad_pkg::LRAD_TGT_CE1;                            // [RQ15] [RQ13]

    end else if (inTrc && (sysMaster == lrad_pkg::LRAD_MST_CPU)) begin
      nextTarget = lrad_pkg::LRAD_TGT_TRACE;                          // [RQ16] [RQ13]
    end else if (inLocal && notVideo) begin
      case (sysQ)
        2'h0:    nextTarget = lrad_pkg::LRAD_TGT_BANK0;               // [RQ13]
        2'h1:    nextTarget = lrad_pkg::LRAD_TGT_BANK1;
        2'h2:    nextTarget = lrad_pkg::LRAD_TGT_ROM;
        default: nextTarget = lrad_pkg::LRAD_TGT_NONE;                // [RQ19]
      endcase
    end
  end

  // Registered route answer, one cycle after the system request.
  // Idle cycles show the NONE target.
  always_ff @(posedge clock) begin
    if (rst) begin
      sysTarget <= lrad_pkg::LRAD_TGT_NONE;
      sysErr    <= 1'b0;
    end else begin
      sysTarget <= sysReq ? nextTarget : lrad_pkg::LRAD_TGT_NONE;
      sysErr    <= sysReq && (nextTarget == lrad_pkg::LRAD_TGT_NONE); // [RQ19]
    end
  end

endmodule : lrad_local_ram_decode

// *** lrad_properties.sv ***
// Concurrent checks on the ports of the local RAM and address decode block.
`timescale 1ns/1ps
module lrad_properties (
  input wire logic                   clock,       // Processor clock.
  input wire logic                   rst,         // Synchronous reset.
  input wire logic                   fetchReq,    // Fetch request.
  input wire logic [31:0]            fetchAddr,   // Fetch address.
  input wire logic                   fetchHit,    // Fetch answered.
  input wire logic                   dataReq,     // Data request.
  input wire logic [31:0]            dataAddr,    // Data address.
  input wire logic                   dataHit,     // Data answered.
  input wire logic                   dataErr,     // Data refused.
  input wire logic                   sysReq,      // System request.
  input wire lrad_pkg::lrad_master_t sysMaster,   // System master.
  input wire logic [31:0]            sysAddr,     // System address.
  input wire lrad_pkg::lrad_target_t sysTarget,   // Routed target.
  input wire logic                   cpReq,       // Transfer valid.
  input wire logic                   cpWrite,     // Write transfer.
  input wire logic                   cpPriv,      // Privileged core.
  input wire logic [3:0]             cpCrn,       // Primary number.
  input wire logic [3:0]             cpCrm,       // Secondary number.
  input wire logic [2:0]             cpOp2,       // Opcode2.
  input wire logic [31:0]            cpRdata,     // Read data.
  input wire logic                   cpAck,       // Accept pulse.
  input wire logic                   cpUndef,     // Refuse pulse.
  input wire logic [31:0]            dataRegion,  // Data region view.
  input wire logic [31:0]            fetchRegion  // Fetch region view.
);
  // Every answer is one cycle after its request, so one clock and one reset serve all checks.
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  status_read_a: assert property (cpReq && cpPriv && !cpWrite && cpCrn == 4'h0 && cpCrm == 4'h0 && cpOp2 == 3'h2
    |=> cpAck && !cpUndef && cpRdata == 32'h00010001) else $error("status read answered wrongly");
  priv_refuse_a: assert property (cpReq && !cpPriv |=> cpUndef && !cpAck) else $error("user transfer not refused");
  idle_quiet_a: assert property (!cpReq |=> !cpAck && !cpUndef) else $error("answer without transfer");
  region_hold_a: assert property (!cpReq |=> $stable(dataRegion)) else $error("region changed unasked");
  fetch_ram_a: assert property (fetchReq && fetchAddr[31:15] == 17'h0 && fetchRegion == 32'h00000019
    |=> fetchHit) else $error("fetch RAM window missed");
  data_ram_a: assert property (dataReq && dataAddr[31:15] == 17'h2 && dataRegion == 32'h00010019
    |=> dataHit && !dataErr) else $error("data RAM window missed");
  res_quarter_a: assert property (dataReq && dataAddr[31:14] == 18'h7 && dataRegion == 32'h00010019
    |=> dataErr && !dataHit) else $error("reserved quarter answered");
  cfg_route_a: assert property (sysReq && sysMaster != lrad_pkg::LRAD_MST_VID && sysAddr[31:22] == 10'h007
    |=> sysTarget == lrad_pkg::LRAD_TGT_CFG) else $error("config space misrouted");
  async_win_a: assert property (sysReq && sysMaster < lrad_pkg::LRAD_MST_PERI && sysAddr[31:25] inside {7'h1, 7'h2}
    |=> sysTarget == ($past(sysAddr[25]) ? lrad_pkg::LRAD_TGT_CE0 : lrad_pkg::LRAD_TGT_CE1))
    else $error("async window misrouted");
endmodule : lrad_properties

// *** lrad_core_model.sv ***
// Processor-side model that issues coprocessor register transfers.
`timescale 1ns/1ps
module lrad_core_model (
  input  wire logic        clock,   // Processor clock.
  input  wire logic [31:0] cpRdata, // Read data.
  input  wire logic        cpAck,   // Accept pulse.
  input  wire logic        cpUndef, // Refuse pulse.
  output logic             cpReq,   // Transfer valid.
  output logic             cpWrite, // Write when high.
  output logic             cpPriv,  // Privileged mode.
  output logic [3:0]       cpCrn,   // Primary number.
  output logic [3:0]       cpCrm,   // Secondary number.
  output logic [2:0]       cpOp2,   // Opcode2.
  output logic [31:0]      cpWdata  // Write data.
);
  // The core starts idle and privileged.
  initial begin
    {cpReq, cpWrite, cpCrn, cpCrm, cpOp2, cpWdata} = '0;
    cpPriv = 1'b1;
  end
  // One transfer, held for the single edge that takes it; the answer is read a cycle later.
  task automatic xfer(input logic w, p, input logic [3:0] n, input logic [2:0] o, input logic [31:0] d,
                      output logic [31:0] r, output logic a, u);
    @(negedge clock);
    {cpReq, cpWrite, cpPriv, cpCrn, cpCrm, cpOp2, cpWdata} = {1'b1, w, p, n, 4'h0, o, d};
    @(negedge clock);
    r = cpRdata;
    a = cpAck;
    u = cpUndef;
    cpReq = 1'b0;
    // Released data shows the inverse so a stale value cannot pass.
    cpWdata = ~d;
  endtask : xfer
endmodule : lrad_core_model

// *** test_local_ram_and_address_decode.sv ***
// Self-checking bench for the local RAM and address decode block.
`timescale 1ns/1ps
module test_local_ram_and_address_decode;
  logic        clock, rst, fetchReq, fetchHit, fetchErr, dataReq, dataWrite, dataHit, dataErr;
  logic        sysReq, sysErr, cpReq, cpWrite, cpPriv, cpAck, cpUndef, ack, undef;
  logic [3:0]  dataBe, cpCrn, cpCrm;
  logic [2:0]  cpOp2;
  logic [31:0] fetchAddr, fetchData, dataAddr, dataWdata, dataRdata, sysAddr, cpWdata, cpRdata;
  logic [31:0] dataRegion, fetchRegion, rd;
  lrad_pkg::lrad_master_t sysMaster;
  lrad_pkg::lrad_target_t sysTarget;
  int          error_cnt, checks;
  lrad_local_ram_decode dut (.*);
  lrad_core_model u_core (.*);
  // Free-running 100 MHz clock.
  always #5 clock = ~clock;
  // Count one comparison and report it at once if it differs.
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Coprocessor transfer through the core model.
  task automatic cp(input logic w, p, input logic [3:0] n, input logic [2:0] o, input logic [31:0] d);
    u_core.xfer(w, p, n, o, d, rd, ack, undef);
  endtask : cp
  // Both local ports in one cycle; answers are settled at the following falling edge.
  task automatic acc(input logic f, input logic [31:0] fa, input logic w, input logic [3:0] be,
                     input logic [31:0] da, wd);
    @(negedge clock);
    {fetchReq, fetchAddr, dataReq, dataWrite, dataBe, dataAddr, dataWdata} = {f, fa, 1'b1, w, be, da, wd};
    @(negedge clock);
    {fetchReq, dataReq} = 2'b00;
    dataWdata = ~wd;
  endtask : acc
  // One routed access of a master, checked against target or refusal.
  task automatic sys(input lrad_pkg::lrad_master_t m, input logic [31:0] a, input lrad_pkg::lrad_target_t t,
                     input logic e);
    @(negedge clock);
    {sysReq, sysMaster, sysAddr} = {1'b1, m, a};
    @(negedge clock);
    sysReq = 1'b0;
    chk(32'(sysErr), 32'(e));
    if (!e) chk(32'(sysTarget), 32'(t));
  endtask : sys
  // Reset values, status word, masking and refused transfers.
  task automatic t_regs;
    chk(dataRegion, 32'h00010019);
    chk(fetchRegion, 32'h00000019);
    cp(1'b0, 1'b1, 4'h0, 3'h2, 32'h0);
    chk({rd[31:1], ack}, 32'h00010001);
    cp(1'b1, 1'b1, 4'h9, 3'h1, 32'hFFFFFFFF);
    cp(1'b0, 1'b1, 4'h9, 3'h1, 32'h0);
    chk(rd, 32'hFFFFF03D);
    cp(1'b1, 1'b0, 4'h9, 3'h0, 32'h0);
    chk(dataRegion ^ 32'(undef), 32'h00010018);
    cp(1'b1, 1'b1, 4'h0, 3'h2, 32'h0);
    chk(32'({ack, undef}), 32'h1);
    cp(1'b1, 1'b1, 4'h9, 3'h1, 32'h00000019);
  endtask : t_regs
  // Byte merge, then a fetch and a data access to different banks in one cycle.
  task automatic t_ram;
    acc(1'b0, 32'h0, 1'b1, 4'hF, 32'h00010004, 32'hAABBCCDD);
    acc(1'b0, 32'h0, 1'b1, 4'h1, 32'h00010004, 32'h11223344);
    acc(1'b0, 32'h0, 1'b1, 4'hF, 32'h00014008, 32'h5A5A5A5A);
    acc(1'b1, 32'h00000004, 1'b0, 4'hF, 32'h00014008, 32'h0);
    chk(32'({fetchHit, dataHit}), 32'h3);
    chk(fetchData, 32'hAABBCC44);
    chk(dataRdata, 32'h5A5A5A5A);
  endtask : t_ram
  // ROM in both windows, a write into ROM, and the reserved quarter.
  task automatic t_rom;
    acc(1'b1, 32'h00008000, 1'b1, 4'hF, 32'h00018000, 32'h12345678);
    chk(32'({fetchHit, fetchErr}), 32'h2);
    acc(1'b1, 32'h0000C000, 1'b0, 4'hF, 32'h00018000, 32'h0);
    chk(32'({fetchErr, dataHit}), 32'h3);
    chk(dataRdata, 32'h0);
    acc(1'b0, 32'h0, 1'b0, 4'hF, 32'h0001C000, 32'h0);
    chk(32'({dataHit, dataErr}), 32'h1);
  endtask : t_rom
  // Absent, reserved and disabled regions, a moved base, then the recommended value.
  task automatic t_size;
    logic [31:0] cfg [3] = '{32'h00010001, 32'h00010005, 32'h00010018};
    foreach (cfg[i]) begin
      cp(1'b1, 1'b1, 4'h9, 3'h0, cfg[i]);
      acc(1'b0, 32'h0, 1'b0, 4'hF, 32'h00010004, 32'h0);
      chk(32'(dataHit), 32'h0);
    end
    cp(1'b1, 1'b1, 4'h9, 3'h0, 32'h0001000D);
    acc(1'b0, 32'h0, 1'b0, 4'hF, 32'h00011000, 32'h0);
    chk(32'({dataHit, dataErr}), 32'h1);
    cp(1'b1, 1'b1, 4'h9, 3'h0, 32'h00020019);
    acc(1'b0, 32'h0, 1'b0, 4'hF, 32'h00020004, 32'h0);
    chk(dataRdata, 32'hAABBCC44);
    cp(1'b1, 1'b1, 4'h9, 3'h0, 32'h00010019);
    acc(1'b0, 32'h0, 1'b0, 4'hF, 32'h00010004, 32'h0);
    chk(dataRdata, 32'hAABBCC44);
  endtask : t_size
  // Per-master routing.
  task automatic t_sys;
    sys(lrad_pkg::LRAD_MST_CPU, 32'h01C20000, lrad_pkg::LRAD_TGT_CFG, 1'b0);
    sys(lrad_pkg::LRAD_MST_DMA, 32'h01FFFFFC, lrad_pkg::LRAD_TGT_CFG, 1'b0);
    sys(lrad_pkg::LRAD_MST_CPU, 32'h02000000, lrad_pkg::LRAD_TGT_CE0, 1'b0);
    sys(lrad_pkg::LRAD_MST_DMA, 32'h05FFFFFC, lrad_pkg::LRAD_TGT_CE1, 1'b0);
    sys(lrad_pkg::LRAD_MST_CPU, 32'h01BC0000, lrad_pkg::LRAD_TGT_TRACE, 1'b0);
    sys(lrad_pkg::LRAD_MST_DMA, 32'h01BC0000, lrad_pkg::LRAD_TGT_NONE, 1'b1);
    sys(lrad_pkg::LRAD_MST_PERI, 32'h02000000, lrad_pkg::LRAD_TGT_NONE, 1'b1);
    sys(lrad_pkg::LRAD_MST_PERI, 32'h00014000, lrad_pkg::LRAD_TGT_BANK1, 1'b0);
    sys(lrad_pkg::LRAD_MST_VID, 32'h01C00000, lrad_pkg::LRAD_TGT_NONE, 1'b1);
    sys(lrad_pkg::LRAD_MST_VID, 32'h80000000, lrad_pkg::LRAD_TGT_DDR, 1'b0);
  endtask : t_sys
  // Print the counts and the verdict, then end the run.
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence: 20 cycles of reset, then each scenario in turn.
  initial begin
    {clock, error_cnt, checks} = '0;
    rst = 1'b1;
    {fetchReq, fetchAddr, dataReq, dataWrite, dataBe, dataAddr, dataWdata, sysReq, sysAddr} = '0;
    sysMaster = lrad_pkg::LRAD_MST_CPU;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    t_regs;
    t_ram;
    t_rom;
    t_size;
    t_sys;
    report_and_stop;
  end
  // A hang costs a mismatch and ends the run.
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    report_and_stop;
  end
endmodule : test_local_ram_and_address_decode
bind lrad_local_ram_decode lrad_properties u_props (.*);
